// [scpo_defs.vh]
// Constants for the stack processor primitive-operation core.
`ifndef SCPO_DEFS_VH
`define SCPO_DEFS_VH

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define SCPO_CLS_HI 15
`define SCPO_CLS_LO 13
`define SCPO_CLS_CALL 3'h0
`define SCPO_CLS_BRANCH 3'h1
`define SCPO_CLS_SLIT 3'h2
`define SCPO_CLS_LLIT 3'h3
`define SCPO_CLS_PRIM 3'h4
`define SCPO_CLS_EXT 3'h5
`define SCPO_CLS_USER 3'h6
`define SCPO_CLS_MEM 3'h7
`define SCPO_BIT_MOD 12
`define SCPO_BIT_WR 7
`define SCPO_BIT_SHA 6
`define SCPO_BIT_RET 5
`define SCPO_BIT_SHB 4
`define SCPO_ALU_HI 11
`define SCPO_ALU_LO 8
`define SCPO_SFT_HI 3
`define SCPO_SFT_LO 0
`define SCPO_ADR_HI 4
`define SCPO_ADR_LO 0
`define SCPO_TGT_HI 12
`define SCPO_TGT_W 13
`define SCPO_ADR_W 5

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define SCPO_SHF_NONE 3'h0
`define SCPO_SHF_EXCH 3'h1
`define SCPO_SHF_DUPLICATE_OP 3'h2
`define SCPO_SHF_OVER 3'h3
`define SCPO_SHF_DROP 3'h4
`define SCPO_ALU_PASS 4'h0
`define SCPO_ALU_AND 4'h1
`define SCPO_ALU_OR 4'h2
`define SCPO_ALU_XOR 4'h3
`define SCPO_ALU_ADD 4'h4
`define SCPO_ALU_SUB 4'h5
`define SCPO_ALU_SEC 4'h6
`define SCPO_SFT_NONE 4'h0
`define SCPO_SFT_SHL 4'h1
`define SCPO_SFT_SHR 4'h2
`define SCPO_SFT_ASR 4'h3
`define SCPO_EXT_LOCAL 3'h7

// ----------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------
`define SCPO_OFF_CTRL 6'h00
`define SCPO_OFF_STATUS 6'h04
`define SCPO_OFF_HEAD 6'h08
`define SCPO_OFF_SECOND 6'h0C
`define SCPO_OFF_PC 6'h10
`define SCPO_OFF_UBASE 6'h14
`define SCPO_OFF_DEPTH 6'h18
`define SCPO_OFF_PERIPH 6'h20
`define SCPO_RST_CTRL 1'h0
`define SCPO_RST_WORD 16'h0000

`endif

// [scpo_stack_ram.v]
// Stack memory with registered read data and write-first bypass.
`timescale 1ns/1ps
`default_nettype none
module scpo_stack_ram #(
  parameter W = 16,
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= {W{1'b0}};
    end else if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // scpo_stack_ram
`default_nettype wire

// [scpo_core.v]
// Primitive-operation core of the stack processor with its register slave.
`timescale 1ns/1ps
`default_nettype none
`include "scpo_defs.vh"
module scpo_core #(
  parameter W = 16,
  parameter SAW = 5
) (
  input wire CLK_SYS,
  input wire RST,
  input wire [5:0] AV_ADDRESS,
  input wire AV_READ,
  input wire AV_WRITE,
  input wire [31:0] AV_WRITEDATA,
  input wire [3:0] AV_BYTEENABLE,
  output reg [31:0] AV_READDATA,
  output wire AV_WAITREQUEST,
  output reg [W-1:0] PM_ADDR,
  output wire PM_RD,
  input wire [W-1:0] PM_RDATA,
  input wire PM_ACK,
  output reg [W-1:0] DM_ADDR,
  output wire DM_RD,
  output wire DM_WR,
  output reg DM_BYTE,
  output reg DM_USER,
  output reg [W-1:0] DM_WDATA,
  input wire [W-1:0] DM_RDATA,
  input wire DM_ACK,
  output reg [4:0] EXT_ADDR,
  output wire EXT_RD,
  output wire EXT_WR,
  output reg [W-1:0] EXT_WDATA,
  input wire [W-1:0] EXT_RDATA,
  input wire EXT_ACK
);
  // ----------------------------------------------------------------
  // States and functions
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_EXEC = 3'h2;
  localparam ST_BUS = 3'h3;
  localparam ST_LIT = 3'h4;

  function [W-1:0] be_merge;
    input [W-1:0] old;
    input [31:0] data;
    input [3:0] be;
    integer k;
    begin
      be_merge = old;
      for (k = 0; k < W / 8; k = k + 1) begin
        if (be[k]) begin
          be_merge[8*k +: 8] = data[8*k +: 8];
        end
      end
    end
  endfunction

  function [SAW-1:0] ptr_dec;
    input [SAW-1:0] p;
    begin
      ptr_dec = p - {{(SAW-1){1'b0}}, 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2:0] state_reg, state_next;
  reg [W-1:0] ir_reg, ir_next;
  reg [W-1:0] head_reg, head_next;
  reg [W-1:0] second_reg, second_next;
  reg [SAW-1:0] psp_reg, psp_next;
  reg [SAW-1:0] rsp_reg, rsp_next;
  reg [W-1:0] ubase_reg;
  reg run_reg;
  reg av_ack_reg;
  reg [W-1:0] periph_reg [0:3];
  reg [W-1:0] pc_next;
  reg ps_we, rs_we;
  reg [W-1:0] ps_wdata;
  reg [W-1:0] dm_addr_next, dm_wdata_next, ext_wdata_next;
  reg dm_byte_next, dm_user_next;
  reg [4:0] ext_addr_next;
  reg periph_we;
  reg fin;
  reg [W-1:0] res, rd_word;
  wire [W-1:0] ptop, rtop;
  integer i;

  wire [2:0] cls = ir_reg[`SCPO_CLS_HI:`SCPO_CLS_LO];
  wire mod_bit = ir_reg[`SCPO_BIT_MOD];
  wire wr_bit = ir_reg[`SCPO_BIT_WR];
  wire [3:0] alu_sel = ir_reg[`SCPO_ALU_HI:`SCPO_ALU_LO];
  wire [3:0] sft_sel = ir_reg[`SCPO_SFT_HI:`SCPO_SFT_LO];
  wire [4:0] adr = ir_reg[`SCPO_ADR_HI:`SCPO_ADR_LO];
  wire [2:0] shf = {ir_reg[`SCPO_BIT_SHB], ir_reg[`SCPO_BIT_WR], ir_reg[`SCPO_BIT_SHA]};
  wire ext_local = (adr[4:2] == `SCPO_EXT_LOCAL);
  wire do_ret = ir_reg[`SCPO_BIT_RET] && cls != `SCPO_CLS_CALL &&
                cls != `SCPO_CLS_BRANCH;
  wire [W-1:0] tgt = {{(W-`SCPO_TGT_W){1'b0}}, ir_reg[`SCPO_TGT_HI:0]};
  wire in_bus = (state_reg == ST_BUS);
  wire is_ext = (cls == `SCPO_CLS_EXT);
  wire av_wr_go = AV_WRITE && av_ack_reg;
  wire [3:0] av_idx = AV_ADDRESS[5:2];
  wire idle_wr = av_wr_go && state_reg == ST_IDLE;

  assign AV_WAITREQUEST = (AV_READ || AV_WRITE) && !av_ack_reg;
  assign PM_RD = (state_reg == ST_FETCH) || (state_reg == ST_LIT);
  assign DM_RD = in_bus && !is_ext && !wr_bit;
  assign DM_WR = in_bus && !is_ext && wr_bit;
  assign EXT_RD = in_bus && is_ext && !wr_bit;
  assign EXT_WR = in_bus && is_ext && wr_bit;

  scpo_stack_ram #(.W(W), .AW(SAW)) u_pstack (
    .clk(CLK_SYS),
    .rst(RST),
    .we(ps_we),
    .waddr(psp_reg),
    .wdata(ps_wdata),
    .raddr(ptr_dec(psp_next)),
    .rdata(ptop)
  );

  scpo_stack_ram #(.W(W), .AW(SAW)) u_rstack (
    .clk(CLK_SYS),
    .rst(RST),
    .we(rs_we),
    .waddr(rsp_reg),
    .wdata(PM_ADDR),
    .raddr(ptr_dec(rsp_next)),
    .rdata(rtop)
  );

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    ir_next = ir_reg;
    head_next = head_reg;
    second_next = second_reg;
    psp_next = psp_reg;
    rsp_next = rsp_reg;
    pc_next = PM_ADDR;
    ps_we = 1'b0;
    ps_wdata = second_reg;
    rs_we = 1'b0;
    dm_addr_next = DM_ADDR;
    dm_wdata_next = DM_WDATA;
    dm_byte_next = DM_BYTE;
    dm_user_next = DM_USER;
    ext_addr_next = EXT_ADDR;
    ext_wdata_next = EXT_WDATA;
    periph_we = 1'b0;
    fin = 1'b0;
    res = head_reg;
    rd_word = DM_BYTE ? {{(W-8){1'b0}}, DM_RDATA[7:0]} : DM_RDATA;
    case (state_reg)
      ST_IDLE: begin
        if (idle_wr && av_idx == `SCPO_OFF_HEAD >> 2) begin
          head_next = AV_WRITEDATA[W-1:0];
        end
        if (idle_wr && av_idx == `SCPO_OFF_SECOND >> 2) begin
          second_next = AV_WRITEDATA[W-1:0];
        end
        if (idle_wr && av_idx == `SCPO_OFF_PC >> 2) begin
          pc_next = AV_WRITEDATA[W-1:0];
        end
        if (run_reg) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (PM_ACK) begin
          ir_next = PM_RDATA;
          pc_next = PM_ADDR + {{(W-1){1'b0}}, 1'b1};
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (cls)
          `SCPO_CLS_CALL: begin
            rs_we = 1'b1;
            rsp_next = rsp_reg + {{(SAW-1){1'b0}}, 1'b1};
            pc_next = tgt;
            fin = 1'b1;
          end
          `SCPO_CLS_BRANCH: begin
            pc_next = tgt;
            fin = 1'b1;
          end
          `SCPO_CLS_SLIT: begin
            ps_we = 1'b1;
            psp_next = psp_reg + {{(SAW-1){1'b0}}, 1'b1};
            second_next = head_reg;
            head_next = {{(W-`SCPO_ADR_W){1'b0}}, adr};
            fin = 1'b1;
          end
          `SCPO_CLS_LLIT: begin
            state_next = ST_LIT;
          end
          `SCPO_CLS_PRIM: begin
            case (shf)
              `SCPO_SHF_EXCH: begin
                head_next = second_reg;
                second_next = head_reg;
              end
              `SCPO_SHF_DUPLICATE_OP: begin
                ps_we = 1'b1;
                psp_next = psp_reg + {{(SAW-1){1'b0}}, 1'b1};
                second_next = head_reg;
              end
              `SCPO_SHF_OVER: begin
                ps_we = 1'b1;
                psp_next = psp_reg + {{(SAW-1){1'b0}}, 1'b1};
                head_next = second_reg;
                second_next = head_reg;
              end
              `SCPO_SHF_DROP: begin
                head_next = second_reg;
                second_next = ptop;
                psp_next = ptr_dec(psp_reg);
              end
              default: begin
                case (alu_sel)
                  `SCPO_ALU_AND: res = second_reg & head_reg;
                  `SCPO_ALU_OR: res = second_reg | head_reg;
                  `SCPO_ALU_XOR: res = second_reg ^ head_reg;
                  `SCPO_ALU_ADD: res = second_reg + head_reg;
                  `SCPO_ALU_SUB: res = second_reg - head_reg;
                  `SCPO_ALU_SEC: res = second_reg;
                  default: res = head_reg;
                endcase
                if (alu_sel != `SCPO_ALU_PASS) begin
                  second_next = ptop;
                  psp_next = ptr_dec(psp_reg);
                end
                case (sft_sel)
                  `SCPO_SFT_SHL: head_next = {res[W-2:0], 1'b0};
                  `SCPO_SFT_SHR: head_next = {1'b0, res[W-1:1]};
                  `SCPO_SFT_ASR: head_next = {res[W-1], res[W-1:1]};
                  default: head_next = res;
                endcase
              end
            endcase
            if (mod_bit) begin
              head_next = ~head_next;
            end
            fin = 1'b1;
          end
          `SCPO_CLS_EXT: begin
            if (ext_local) begin
              if (wr_bit) begin
                periph_we = 1'b1;
              end else begin
                head_next = mod_bit ? ~periph_reg[adr[1:0]] : periph_reg[adr[1:0]];
              end
              fin = 1'b1;
            end else begin
              ext_addr_next = adr;
              ext_wdata_next = head_reg;
              state_next = ST_BUS;
            end
          end
          `SCPO_CLS_USER: begin
            dm_addr_next = ubase_reg | {{(W-`SCPO_ADR_W){1'b0}}, adr};
            dm_wdata_next = head_reg;
            dm_byte_next = 1'b0;
            dm_user_next = 1'b1;
            state_next = ST_BUS;
          end
          default: begin
            dm_addr_next = head_reg;
            dm_wdata_next = second_reg;
            dm_byte_next = mod_bit;
            dm_user_next = 1'b0;
            state_next = ST_BUS;
          end
        endcase
      end
      ST_BUS: begin
        if (is_ext && EXT_ACK) begin
          if (!wr_bit) begin
            head_next = mod_bit ? ~EXT_RDATA : EXT_RDATA;
          end
          fin = 1'b1;
        end else if (!is_ext && DM_ACK) begin
          if (!wr_bit) begin
            head_next = rd_word;
          end
          fin = 1'b1;
        end
      end
      ST_LIT: begin
        if (PM_ACK) begin
          ps_we = 1'b1;
          psp_next = psp_reg + {{(SAW-1){1'b0}}, 1'b1};
          second_next = head_reg;
          head_next = PM_RDATA;
          pc_next = PM_ADDR + {{(W-1){1'b0}}, 1'b1};
          fin = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (fin) begin
      if (do_ret) begin
        pc_next = rtop;
        rsp_next = ptr_dec(rsp_reg);
      end
      state_next = run_reg ? ST_FETCH : ST_IDLE;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      ir_reg <= `SCPO_RST_WORD;
      head_reg <= `SCPO_RST_WORD;
      second_reg <= `SCPO_RST_WORD;
      psp_reg <= {SAW{1'b0}};
      rsp_reg <= {SAW{1'b0}};
      PM_ADDR <= `SCPO_RST_WORD;
      DM_ADDR <= `SCPO_RST_WORD;
      DM_WDATA <= `SCPO_RST_WORD;
      DM_BYTE <= 1'b0;
      DM_USER <= 1'b0;
      EXT_ADDR <= 5'h00;
      EXT_WDATA <= `SCPO_RST_WORD;
    end else begin
      state_reg <= state_next;
      ir_reg <= ir_next;
      head_reg <= head_next;
      second_reg <= second_next;
      psp_reg <= psp_next;
      rsp_reg <= rsp_next;
      PM_ADDR <= pc_next;
      DM_ADDR <= dm_addr_next;
      DM_WDATA <= dm_wdata_next;
      DM_BYTE <= dm_byte_next;
      DM_USER <= dm_user_next;
      EXT_ADDR <= ext_addr_next;
      EXT_WDATA <= ext_wdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Register slave and peripheral registers
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      av_ack_reg <= 1'b0;
      run_reg <= `SCPO_RST_CTRL;
      ubase_reg <= `SCPO_RST_WORD;
      AV_READDATA <= 32'h00000000;
      for (i = 0; i < 4; i = i + 1) begin
        periph_reg[i] <= `SCPO_RST_WORD;
      end
    end else begin
      av_ack_reg <= (AV_READ || AV_WRITE) && !av_ack_reg;
      if (av_wr_go && av_idx == `SCPO_OFF_CTRL >> 2 && AV_BYTEENABLE[0]) begin
        run_reg <= AV_WRITEDATA[0];
      end
      if (av_wr_go && av_idx == `SCPO_OFF_UBASE >> 2) begin
        ubase_reg <= be_merge(ubase_reg, AV_WRITEDATA, AV_BYTEENABLE);
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (periph_we && adr[1:0] == i[1:0]) begin
          periph_reg[i] <= head_reg;
        end else if (av_wr_go && av_idx == (`SCPO_OFF_PERIPH >> 2) + i[3:0]) begin
          periph_reg[i] <= be_merge(periph_reg[i], AV_WRITEDATA, AV_BYTEENABLE);
        end
      end
      if (AV_READ && !av_ack_reg) begin
        case (av_idx)
          `SCPO_OFF_CTRL >> 2: AV_READDATA <= {31'h00000000, run_reg};
          `SCPO_OFF_STATUS >> 2: AV_READDATA <= {29'h00000000, state_reg};
          `SCPO_OFF_HEAD >> 2: AV_READDATA <= {{(32-W){1'b0}}, head_reg};
          `SCPO_OFF_SECOND >> 2: AV_READDATA <= {{(32-W){1'b0}}, second_reg};
          `SCPO_OFF_PC >> 2: AV_READDATA <= {{(32-W){1'b0}}, PM_ADDR};
          `SCPO_OFF_UBASE >> 2: AV_READDATA <= {{(32-W){1'b0}}, ubase_reg};
          `SCPO_OFF_DEPTH >> 2: AV_READDATA <= {{(24-SAW){1'b0}}, rsp_reg, 3'h0,
                                                 psp_reg};
          (`SCPO_OFF_PERIPH >> 2): AV_READDATA <= {{(32-W){1'b0}}, periph_reg[0]};
          (`SCPO_OFF_PERIPH >> 2) + 1: AV_READDATA <= {{(32-W){1'b0}}, periph_reg[1]};
          (`SCPO_OFF_PERIPH >> 2) + 2: AV_READDATA <= {{(32-W){1'b0}}, periph_reg[2]};
          (`SCPO_OFF_PERIPH >> 2) + 3: AV_READDATA <= {{(32-W){1'b0}}, periph_reg[3]};
          default: AV_READDATA <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // scpo_core
`default_nettype wire

// [scpo_monitor.sv]
// Concurrent checks on the ports of the primitive-operation core.
`timescale 1ns/1ps
`default_nettype none
module scpo_monitor (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic AV_READ,
  input wire logic AV_WRITE,
  input wire logic [31:0] AV_READDATA,
  input wire logic AV_WAITREQUEST,
  input wire logic [15:0] PM_ADDR,
  input wire logic PM_RD,
  input wire logic PM_ACK,
  input wire logic [15:0] DM_ADDR,
  input wire logic DM_RD,
  input wire logic DM_WR,
  input wire logic DM_BYTE,
  input wire logic DM_USER,
  input wire logic DM_ACK,
  input wire logic [4:0] EXT_ADDR,
  input wire logic EXT_RD,
  input wire logic EXT_WR,
  input wire logic EXT_ACK
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_fetch;
    PM_RD && PM_ACK;
  endsequence
  sequence s_av_new;
    (AV_READ || AV_WRITE) && AV_WAITREQUEST;
  endsequence
  sequence s_dm_wait;
    (DM_RD || DM_WR) && !DM_ACK;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_av_wait;
    s_av_new |=> !AV_WAITREQUEST;
  endproperty
  property p_av_idle;
    !AV_READ && !AV_WRITE |-> !AV_WAITREQUEST;
  endproperty
  property p_rd_hi;
    AV_READ && !AV_WAITREQUEST |-> AV_READDATA[31:16] == 16'h0000;
  endproperty
  property p_pc_step;
    s_fetch ##1 !PM_RD |-> PM_ADDR == $past(PM_ADDR) + 16'h0001;
  endproperty
  property p_pm_hold;
    PM_RD && !PM_ACK |=> PM_RD && $stable(PM_ADDR);
  endproperty
  property p_dm_hold;
    s_dm_wait |=> $stable({DM_RD, DM_WR, DM_ADDR});
  endproperty
  property p_dm_excl;
    !(DM_RD && DM_WR);
  endproperty
  property p_user_word;
    (DM_RD || DM_WR) && DM_USER |-> !DM_BYTE;
  endproperty
  property p_ext_hold;
    (EXT_RD || EXT_WR) && !EXT_ACK |=> $stable({EXT_RD, EXT_WR, EXT_ADDR});
  endproperty
  a_av_wait: assert property (p_av_wait) else $error("waitrequest too long");
  a_av_idle: assert property (p_av_idle) else $error("waitrequest without request");
  a_rd_hi: assert property (p_rd_hi) else $error("upper read data not zero");
  a_pc_step: assert property (p_pc_step) else $error("pc did not step");
  a_pm_hold: assert property (p_pm_hold) else $error("fetch dropped early");
  a_dm_hold: assert property (p_dm_hold) else $error("memory request moved");
  a_dm_excl: assert property (p_dm_excl) else $error("read and write together");
  a_user_word: assert property (p_user_word) else $error("user byte access");
  a_ext_hold: assert property (p_ext_hold) else $error("bus request moved");
endmodule // scpo_monitor
bind scpo_core scpo_monitor scpo_monitor_inst (.CLK_SYS, .RST, .AV_READ, .AV_WRITE,
  .AV_READDATA, .AV_WAITREQUEST, .PM_ADDR, .PM_RD, .PM_ACK, .DM_ADDR, .DM_RD, .DM_WR,
  .DM_BYTE, .DM_USER, .DM_ACK, .EXT_ADDR, .EXT_RD, .EXT_WR, .EXT_ACK);
`default_nettype wire

// [scpo_far_model.sv]
// Program memory, data memory and extension devices around the core.
`timescale 1ns/1ps
`default_nettype none
module scpo_far_model (
  input wire logic CLK_SYS,
  input wire logic SLOW,
  input wire logic [15:0] PM_ADDR,
  input wire logic PM_RD,
  output logic [15:0] PM_RDATA,
  output logic PM_ACK,
  input wire logic [15:0] DM_ADDR,
  input wire logic DM_RD,
  input wire logic DM_WR,
  input wire logic DM_BYTE,
  input wire logic DM_USER,
  input wire logic [15:0] DM_WDATA,
  output logic [15:0] DM_RDATA,
  output logic DM_ACK,
  input wire logic [4:0] EXT_ADDR,
  input wire logic EXT_RD,
  input wire logic EXT_WR,
  input wire logic [15:0] EXT_WDATA,
  output logic [15:0] EXT_RDATA,
  output logic EXT_ACK
);
  logic [15:0] pm [0:255];
  logic [15:0] dm [0:255];
  logic [15:0] um [0:255];
  logic [15:0] ext [0:31];
  logic [15:0] cnt;
  logic ph;
  initial begin
    cnt = 16'h0000;
    ph = 1'b0;
    for (int i = 0; i < 256; i++) pm[i] = 16'h8000;
  end
  // Acks come every cycle, or every second cycle when slow.
  assign PM_ACK = PM_RD && (!SLOW || ph);
  assign DM_ACK = (DM_RD || DM_WR) && (!SLOW || ph);
  assign EXT_ACK = (EXT_RD || EXT_WR) && (!SLOW || ph);
  // Released data lines show a changing pattern.
  assign PM_RDATA = PM_RD ? pm[PM_ADDR[7:0]] : cnt;
  assign DM_RDATA = DM_RD ? (DM_USER ? um[DM_ADDR[7:0]] : dm[DM_ADDR[7:0]]) : ~cnt;
  assign EXT_RDATA = EXT_RD ? ext[EXT_ADDR] : cnt ^ 16'h5A5A;
  always @(posedge CLK_SYS) begin
    cnt <= cnt + 16'h0001;
    ph <= ~ph;
    if (DM_WR && DM_ACK) begin
      if (DM_USER) um[DM_ADDR[7:0]] <= DM_WDATA;
      else if (DM_BYTE) dm[DM_ADDR[7:0]][7:0] <= DM_WDATA[7:0];
      else dm[DM_ADDR[7:0]] <= DM_WDATA;
    end
    if (EXT_WR && EXT_ACK) ext[EXT_ADDR] <= EXT_WDATA;
  end
endmodule // scpo_far_model
`default_nettype wire

// [stack_cpu_primitive_ops_tb_top.sv]
// Self-checking testbench of the primitive-operation core.
`timescale 1ns/1ps
`default_nettype none
module stack_cpu_primitive_ops_tb_top;
  logic CLK_SYS, RST, AV_READ, AV_WRITE, AV_WAITREQUEST, PM_RD, PM_ACK, SLOW;
  logic DM_RD, DM_WR, DM_BYTE, DM_USER, DM_ACK, EXT_RD, EXT_WR, EXT_ACK;
  logic [5:0] AV_ADDRESS;
  logic [31:0] AV_WRITEDATA, AV_READDATA, rd;
  logic [3:0] AV_BYTEENABLE;
  logic [15:0] PM_ADDR, PM_RDATA, DM_ADDR, DM_WDATA, DM_RDATA, EXT_WDATA, EXT_RDATA;
  logic [4:0] EXT_ADDR;
  int n_fail, num_checks;
  scpo_core scpo_core_inst (.CLK_SYS, .RST, .AV_ADDRESS, .AV_READ, .AV_WRITE,
    .AV_WRITEDATA, .AV_BYTEENABLE, .AV_READDATA, .AV_WAITREQUEST, .PM_ADDR, .PM_RD,
    .PM_RDATA, .PM_ACK, .DM_ADDR, .DM_RD, .DM_WR, .DM_BYTE, .DM_USER, .DM_WDATA,
    .DM_RDATA, .DM_ACK, .EXT_ADDR, .EXT_RD, .EXT_WR, .EXT_WDATA, .EXT_RDATA, .EXT_ACK);
  scpo_far_model scpo_far_model_inst (.CLK_SYS, .SLOW, .PM_ADDR, .PM_RD, .PM_RDATA,
    .PM_ACK, .DM_ADDR, .DM_RD, .DM_WR, .DM_BYTE, .DM_USER, .DM_WDATA, .DM_RDATA,
    .DM_ACK, .EXT_ADDR, .EXT_RD, .EXT_WR, .EXT_WDATA, .EXT_RDATA, .EXT_ACK);
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Avalon access: held until waitrequest is sampled low.
  task av(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AV_ADDRESS <= a;
    AV_WRITEDATA <= d;
    AV_WRITE <= wr;
    AV_READ <= !wr;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AV_WAITREQUEST !== 1'b0 && n < 50);
    rd = AV_READDATA;
    AV_WRITE <= 1'b0;
    AV_READ <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      conclude;
    end
  endtask
  task ld(input int a, input logic [15:0] p [$]);
    foreach (p[i]) scpo_far_model_inst.pm[a + i] = p[i];
  endtask
  // Runs from start until the fetch address reaches stop, then halts.
  task run(input logic [15:0] start, input logic [15:0] stop);
    int n;
    n = 0;
    av(1'b1, 6'h10, {16'h0000, start});
    av(1'b1, 6'h00, 32'h00000001);
    while (PM_ADDR !== stop && n < 2000) begin
      @(posedge CLK_SYS);
      n++;
    end
    if (n >= 2000) n_fail++;
    av(1'b1, 6'h00, 32'h00000000);
    do begin
      av(1'b0, 6'h04, 32'h0);
      n++;
    end while (rd[2:0] !== 3'h0 && n < 2100);
    if (n >= 2100) begin
      n_fail++;
      conclude;
    end
  endtask
  task head_second(input logic [15:0] h, input logic [15:0] s);
    av(1'b0, 6'h08, 32'h0);
    check(rd, {16'h0000, h});
    av(1'b0, 6'h0C, 32'h0);
    check(rd, {16'h0000, s});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_shuffle;
    av(1'b1, 6'h08, 32'h00001111);
    av(1'b1, 6'h0C, 32'h00002222);
    ld(0, '{16'h5FDF, 16'h6000, 16'hABCD, 16'h80C0, 16'h8040, 16'h8080, 16'h8010,
      16'h8010, 16'h8010, 16'h9000});
    run(16'h0000, 16'h000A);
    head_second(16'hFFE0, 16'h1111);
    av(1'b0, 6'h18, 32'h0);
    check(rd & 32'h0000001F, 32'h00000001);
    ld(16, '{16'h8400, 16'h8001});
    run(16'h0010, 16'h0012);
    head_second(16'h21E2, 16'h2222);
    $display("shuffle test done");
  endtask
  task t_memory;
    SLOW <= 1'b1;
    av(1'b1, 6'h08, 32'h00000040);
    av(1'b1, 6'h0C, 32'h00005A5A);
    scpo_far_model_inst.dm[5] = 16'h1234;
    scpo_far_model_inst.dm[64] = 16'h7E7E;
    ld(32, '{16'h4005, 16'hF000, 16'h8040, 16'hE080, 16'hE000});
    run(16'h0020, 16'h0025);
    check({16'h0000, scpo_far_model_inst.dm[64]}, 32'h00000034);
    head_second(16'h0034, 16'h0034);
    SLOW <= 1'b0;
    $display("memory test done");
  endtask
  task t_bus;
    av(1'b1, 6'h14, 32'h00000020);
    av(1'b1, 6'h24, 32'h00006161);
    av(1'b1, 6'h08, 32'h00007777);
    scpo_far_model_inst.um[36] = 16'h3C3C;
    scpo_far_model_inst.ext[5] = 16'h4242;
    ld(64, '{16'hC083, 16'hC004, 16'hA082, 16'hA005, 16'hA09C, 16'hA01D});
    run(16'h0040, 16'h0046);
    check({16'h0000, scpo_far_model_inst.um[35]}, 32'h00007777);
    check({16'h0000, scpo_far_model_inst.ext[2]}, 32'h00003C3C);
    av(1'b0, 6'h20, 32'h0);
    check(rd, 32'h00004242);
    av(1'b0, 6'h08, 32'h0);
    check(rd, 32'h00006161);
    av(1'b1, 6'h1C, 32'h0000FFFF);
    av(1'b0, 6'h1C, 32'h0);
    check(rd, 32'h00000000);
    $display("bus test done");
  endtask
  task t_return;
    ld(96, '{16'h0070, 16'h4003});
    ld(112, '{16'h4027});
    run(16'h0060, 16'h0062);
    head_second(16'h0003, 16'h0007);
    $display("return test done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    num_checks = 0;
    RST = 1'b1;
    SLOW = 1'b0;
    AV_READ = 1'b0;
    AV_WRITE = 1'b0;
    AV_ADDRESS = 6'h00;
    AV_WRITEDATA = 32'h0;
    AV_BYTEENABLE = 4'hF;
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    head_second(16'h0000, 16'h0000);
    t_shuffle;
    t_memory;
    t_bus;
    t_return;
    conclude;
  end
endmodule // stack_cpu_primitive_ops_tb_top
`default_nettype wire
